//--- src/ifd_decoder.v
// Instruction field decoder with APB status and control registers
// Overview of operation
// - Opcode taken from big-endian bits zero to five
// - Bits six to thirty are operands, extended opcode
// - Absolute flag picks direct or PC-relative target
// - Conditional branch displacement is fourteen bits
// - Compare destination selects one of eight fields
// - Load/store displacement sign-extended from sixteen bits
// - Fourteen-bit effective-address displacement extracted
// - Branch immediate 24 bits, two zeros, sign-extended
// - Link flag writes next address to link
// - Mask begin and end give bit positions
// - Byte count field gives string transfer length
// - Overflow enable lets overflow update exception bits
// - Compare immediate sign-extended from sixteen bits
// - Unsigned immediate zero-extended, no sign extension
// - Trap mask ANDed with compares; any bit traps
// - Record bit decides condition register update
// - Condition bit fields: two sources, one target
// - Register index fields name sources and destination
// - Floating indices: three sources, target, store source
`timescale 1ns/1ps
`include "ifd_defs.vh"
`default_nettype none

module ifd_decoder #(
  parameter integer CNT_W = 32
) (
  input  wire        mclk,
  input  wire        sys_rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        fetch_valid,
  input  wire [31:0] fetch_instr,
  input  wire [31:0] fetch_pc,
  input  wire        exe_result_valid,
  input  wire [31:0] exe_result,
  input  wire        exe_overflow,
  input  wire [4:0]  exe_trap_cmp,
  output reg         dec_valid_ff,
  output reg  [5:0]  opcode_ff,
  output reg  [9:0]  ext_opcode_ff,
  output reg  [4:0]  gpr_dest_ff,
  output reg  [4:0]  gpr_store_src_ff,
  output reg  [4:0]  gpr_src_a_ff,
  output reg  [4:0]  gpr_src_b_ff,
  output reg  [4:0]  fpr_dest_ff,
  output reg  [4:0]  fpr_store_src_ff,
  output reg  [4:0]  fpr_src_a_ff,
  output reg  [4:0]  fpr_src_b_ff,
  output reg  [4:0]  fpr_src_c_ff,
  output reg  [2:0]  cr_field_dest_ff,
  output reg  [4:0]  cr_dest_bit_ff,
  output reg  [4:0]  cr_src_bit_a_ff,
  output reg  [4:0]  cr_src_bit_b_ff,
  output reg  [31:0] disp_imm_ff,
  output reg  [31:0] compare_imm_ff,
  output reg  [31:0] unsigned_imm_ff,
  output reg  [31:0] ea_disp_ff,
  output reg  [31:0] cond_branch_disp_ff,
  output reg  [31:0] cond_branch_target_ff,
  output reg  [31:0] branch_target_ff,
  output reg         absolute_addr_flag_ff,
  output reg         link_flag_ff,
  output reg         link_wr_ff,
  output reg  [31:0] link_addr_ff,
  output reg  [4:0]  mask_begin_ff,
  output reg  [4:0]  mask_end_bit_ff,
  output reg  [5:0]  string_byte_count_ff,
  output reg         ovf_enable_ff,
  output reg  [4:0]  trap_condition_mask_ff,
  output reg         record_ff,
  output reg         rsv_nonzero_ff,
  output reg         cr_wr_ff,
  output reg  [3:0]  cr0_ff,
  output reg         xer_ov_ff,
  output reg         xer_so_ff,
  output reg         trap_ff
);

  // Sign extension helpers shared by several immediates
  function [31:0] sext16;
    input [15:0] v;
    begin
      sext16 = {{16{v[15]}}, v};
    end
  endfunction

  function [31:0] sext14w;
    input [13:0] v;
    begin
      sext14w = {{16{v[13]}}, v, 2'b00};
    end
  endfunction

  // Compare forms are the only words that carry the length selector
  function is_cmp_form;
    input [5:0] op;
    input [9:0] xo;
    begin
      is_cmp_form = (op == `IFD_OP_CMPI) | (op == `IFD_OP_CMPLI) |
                    ((op == `IFD_OP_EXT31) &
                     ((xo == `IFD_XO_CMP) | (xo == `IFD_XO_CMPL)));
    end
  endfunction

  reg  [1:0]       ctrl_ff;
  reg  [3:0]       status_ff;
  reg  [CNT_W-1:0] count_ff;
  reg  [31:0]      last_instr_ff;
  reg  [1:0]       nxt_ctrl;
  reg  [3:0]       nxt_status;
  reg  [31:0]      nxt_rdata;
  reg              nxt_slverr;
  reg  [31:0]      nxt_cond_target;
  reg  [31:0]      nxt_branch_target;
  reg  [31:0]      nxt_link_addr;

  wire        take     = fetch_valid & ctrl_ff[`IFD_CTRL_EN_BIT];
  wire [5:0]  f_op     = fetch_instr[`IFD_OPCODE_HI:`IFD_OPCODE_LO];
  wire [9:0]  f_xo     = fetch_instr[`IFD_XO_HI:`IFD_XO_LO];
  wire [4:0]  f_rt     = fetch_instr[`IFD_RT_HI:`IFD_RT_LO];
  wire [4:0]  f_ra     = fetch_instr[`IFD_RA_HI:`IFD_RA_LO];
  wire [4:0]  f_rb     = fetch_instr[`IFD_RB_HI:`IFD_RB_LO];
  wire [4:0]  f_rc     = fetch_instr[`IFD_RC_HI:`IFD_RC_LO];
  wire [15:0] f_imm    = fetch_instr[`IFD_IMM_HI:`IFD_IMM_LO];
  wire [13:0] f_bd     = fetch_instr[`IFD_BD_HI:`IFD_BD_LO];
  wire [23:0] f_li     = fetch_instr[`IFD_LI_HI:`IFD_LI_LO];
  wire        f_aa     = fetch_instr[`IFD_AA_BIT];
  wire        f_lk     = fetch_instr[`IFD_LK_BIT];
  wire [31:0] li_ext   = {{6{f_li[23]}}, f_li, 2'b00};
  wire [31:0] bd_ext   = sext14w(f_bd);

  // Only compare forms carry the length selector; anything else would false-flag
  wire        has_lsel = is_cmp_form(f_op, f_xo);
  wire        lsel_bad = has_lsel & fetch_instr[`IFD_LSEL_BIT];

  wire        apb_acc  = psel & penable & ~pready;
  wire        apb_wr   = apb_acc & pwrite;
  wire        sel_ctrl = paddr == `IFD_REG_CTRL;
  wire        sel_stat = paddr == `IFD_REG_STATUS;
  wire        sel_cnt  = paddr == `IFD_REG_COUNT;
  wire        sel_last = paddr == `IFD_REG_LAST;
  wire        mapped   = sel_ctrl | sel_stat | sel_cnt | sel_last;
  wire        clr_xer  = apb_wr & sel_ctrl & pwdata[`IFD_CTRL_CLRX_BIT];

  // Condition register field 0 follows the result sign and summary overflow
  wire        res_lt   = exe_result[31];
  wire        res_eq   = exe_result == 32'h0000_0000;
  wire        ov_event = exe_result_valid & ovf_enable_ff & exe_overflow;
  wire        trap_hit = |(trap_condition_mask_ff & exe_trap_cmp);

  // Branch targets: the absolute flag bypasses the adder
  always @* begin
    nxt_link_addr = fetch_pc + 32'h0000_0004;
    if (f_aa) begin
      nxt_cond_target   = bd_ext;
      nxt_branch_target = li_ext;
    end else begin
      nxt_cond_target   = fetch_pc + bd_ext;
      nxt_branch_target = fetch_pc + li_ext;
    end
  end

  // Decode stage: every field registered in the cycle after the fetch word
  always @(posedge mclk) begin
    if (sys_rst) begin
      dec_valid_ff          <= 1'b0;
      opcode_ff             <= 6'h00;
      ext_opcode_ff         <= 10'h000;
      gpr_dest_ff           <= 5'h00;
      gpr_store_src_ff      <= 5'h00;
      gpr_src_a_ff          <= 5'h00;
      gpr_src_b_ff          <= 5'h00;
      fpr_dest_ff           <= 5'h00;
      fpr_store_src_ff      <= 5'h00;
      fpr_src_a_ff          <= 5'h00;
      fpr_src_b_ff          <= 5'h00;
      fpr_src_c_ff          <= 5'h00;
      cr_field_dest_ff      <= 3'h0;
      cr_dest_bit_ff        <= 5'h00;
      cr_src_bit_a_ff       <= 5'h00;
      cr_src_bit_b_ff       <= 5'h00;
      disp_imm_ff           <= 32'h0000_0000;
      compare_imm_ff        <= 32'h0000_0000;
      unsigned_imm_ff       <= 32'h0000_0000;
      ea_disp_ff            <= 32'h0000_0000;
      cond_branch_disp_ff   <= 32'h0000_0000;
      cond_branch_target_ff <= 32'h0000_0000;
      branch_target_ff      <= 32'h0000_0000;
      absolute_addr_flag_ff <= 1'b0;
      link_flag_ff          <= 1'b0;
      link_wr_ff            <= 1'b0;
      link_addr_ff          <= 32'h0000_0000;
      mask_begin_ff         <= 5'h00;
      mask_end_bit_ff       <= 5'h00;
      string_byte_count_ff  <= 6'h00;
      ovf_enable_ff         <= 1'b0;
      trap_condition_mask_ff <= 5'h00;
      record_ff             <= 1'b0;
      rsv_nonzero_ff        <= 1'b0;
    end else begin
      dec_valid_ff <= take;
      link_wr_ff   <= take & f_lk;
      if (take) begin
        opcode_ff        <= f_op;
        ext_opcode_ff    <= f_xo;
        gpr_dest_ff      <= f_rt;
        gpr_store_src_ff <= f_rt;
        gpr_src_a_ff     <= f_ra;
        gpr_src_b_ff     <= f_rb;
        fpr_dest_ff      <= f_rt;
        fpr_store_src_ff <= f_rt;
        fpr_src_a_ff     <= f_ra;
        fpr_src_b_ff     <= f_rb;
        fpr_src_c_ff     <= f_rc;
        cr_field_dest_ff <= fetch_instr[`IFD_BF_HI:`IFD_BF_LO];
        cr_dest_bit_ff   <= f_rt;
        cr_src_bit_a_ff  <= f_ra;
        cr_src_bit_b_ff  <= f_rb;
        disp_imm_ff      <= sext16(f_imm);
        compare_imm_ff   <= sext16(f_imm);
        unsigned_imm_ff  <= {16'h0000, f_imm};
        ea_disp_ff       <= bd_ext;
        cond_branch_disp_ff <= bd_ext;
        cond_branch_target_ff <= nxt_cond_target;
        branch_target_ff      <= nxt_branch_target;
        absolute_addr_flag_ff <= f_aa;
        link_flag_ff     <= f_lk;
        link_addr_ff     <= nxt_link_addr;
        mask_begin_ff    <= fetch_instr[`IFD_MB_HI:`IFD_MB_LO];
        mask_end_bit_ff  <= fetch_instr[`IFD_ME_HI:`IFD_ME_LO];
        // A zero count moves a full 32 bytes
        string_byte_count_ff <= (f_rb == 5'h00) ? 6'h20 : {1'b0, f_rb};
        ovf_enable_ff    <= fetch_instr[`IFD_OE_BIT];
        trap_condition_mask_ff <= f_rt;
        record_ff        <= fetch_instr[`IFD_REC_BIT];
        rsv_nonzero_ff   <= lsel_bad;
      end
    end
  end

  // Execute-side effects steered by the decoded qualifiers
  always @(posedge mclk) begin
    if (sys_rst) begin
      cr_wr_ff  <= 1'b0;
      cr0_ff    <= 4'h0;
      xer_ov_ff <= 1'b0;
      xer_so_ff <= 1'b0;
      trap_ff   <= 1'b0;
    end else begin
      cr_wr_ff <= exe_result_valid & record_ff;
      if (exe_result_valid & record_ff) begin
        cr0_ff <= {res_lt, ~res_lt & ~res_eq, res_eq, xer_so_ff | ov_event};
      end
      // Overflow wins over a software clear in the same cycle
      if (ov_event) begin
        xer_ov_ff <= 1'b1;
      end else if (clr_xer | (exe_result_valid & ovf_enable_ff)) begin
        xer_ov_ff <= 1'b0;
      end
      // Summary bit survives clean results, only software clears it
      if (ov_event) begin
        xer_so_ff <= 1'b1;
      end else if (clr_xer) begin
        xer_so_ff <= 1'b0;
      end
      trap_ff <= exe_result_valid & trap_hit;
    end
  end

  // Sticky status: hardware set beats write-one-to-clear
  always @* begin
    nxt_status = status_ff;
    if (apb_wr & sel_stat) begin
      nxt_status = status_ff & ~pwdata[3:0];
    end
    if (ov_event) begin
      nxt_status[`IFD_ST_OV_BIT] = 1'b1;
    end
    nxt_status[`IFD_ST_SO_BIT] = xer_so_ff | ov_event;
    if (exe_result_valid & trap_hit) begin
      nxt_status[`IFD_ST_TRAP_BIT] = 1'b1;
    end
    if (take & lsel_bad) begin
      nxt_status[`IFD_ST_RSV_BIT] = 1'b1;
    end
  end

  always @* begin
    nxt_ctrl = ctrl_ff;
    if (apb_wr & sel_ctrl) begin
      nxt_ctrl = {1'b0, pwdata[`IFD_CTRL_EN_BIT]};
    end
  end

  always @* begin
    nxt_rdata  = 32'h0000_0000;
    nxt_slverr = ~mapped;
    if (sel_ctrl) begin
      nxt_rdata = {30'h0, ctrl_ff};
    end else if (sel_stat) begin
      nxt_rdata = {28'h000_0000, status_ff};
    end else if (sel_cnt) begin
      nxt_rdata[CNT_W-1:0] = count_ff;
    end else if (sel_last) begin
      nxt_rdata = last_instr_ff;
    end
  end

  // APB slave: one wait state, so pready and read data leave flip-flops
  always @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_ff       <= `IFD_CTRL_RESET;
      status_ff     <= 4'h0;
      count_ff      <= {CNT_W{1'b0}};
      last_instr_ff <= 32'h0000_0000;
      pready        <= 1'b0;
      prdata        <= 32'h0000_0000;
      pslverr       <= 1'b0;
    end else begin
      ctrl_ff   <= nxt_ctrl;
      status_ff <= nxt_status;
      if (take) begin
        count_ff      <= count_ff + {{(CNT_W-1){1'b0}}, 1'b1};
        last_instr_ff <= fetch_instr;
      end
      pready  <= apb_acc;
      pslverr <= apb_acc & nxt_slverr;
      if (apb_acc & ~pwrite) begin
        prdata <= nxt_rdata;
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

endmodule // ifd_decoder

`default_nettype wire

//--- src/ifd_defs.vh
// Field positions, register map and reset values for the instruction field decoder
`ifndef IFD_DEFS_VH
`define IFD_DEFS_VH

// Instruction fields as little-endian slices (word bit 0 here is big-endian bit 31)
`define IFD_OPCODE_HI     31
`define IFD_OPCODE_LO     26
`define IFD_OPER_HI       25
`define IFD_OPER_LO       1
`define IFD_RT_HI         25
`define IFD_RT_LO         21
`define IFD_RA_HI         20
`define IFD_RA_LO         16
`define IFD_RB_HI         15
`define IFD_RB_LO         11
`define IFD_RC_HI         10
`define IFD_RC_LO         6
`define IFD_BF_HI         25
`define IFD_BF_LO         23
`define IFD_LSEL_BIT      21
`define IFD_BD_HI         15
`define IFD_BD_LO         2
`define IFD_LI_HI         25
`define IFD_LI_LO         2
`define IFD_AA_BIT        1
`define IFD_LK_BIT        0
`define IFD_REC_BIT       0
`define IFD_OE_BIT        10
`define IFD_XO_HI         10
`define IFD_XO_LO         1
`define IFD_MB_HI         10
`define IFD_MB_LO         6
`define IFD_ME_HI         5
`define IFD_ME_LO         1
`define IFD_IMM_HI        15
`define IFD_IMM_LO        0

// Primary and extended opcodes that carry the compare length selector
`define IFD_OP_CMPLI      6'h0A
`define IFD_OP_CMPI       6'h0B
`define IFD_OP_EXT31      6'h1F
`define IFD_XO_CMP        10'h000
`define IFD_XO_CMPL       10'h020

// Register byte offsets
`define IFD_REG_CTRL      12'h000
`define IFD_REG_STATUS    12'h004
`define IFD_REG_COUNT     12'h008
`define IFD_REG_LAST      12'h00C

// Control bits
`define IFD_CTRL_EN_BIT   0
`define IFD_CTRL_CLRX_BIT 1
`define IFD_CTRL_RESET    2'h1

// Status bits
`define IFD_ST_OV_BIT     0
`define IFD_ST_SO_BIT     1
`define IFD_ST_TRAP_BIT   2
`define IFD_ST_RSV_BIT    3

`endif

//--- tb/ifd_dec_chk_assertions.sv
// Concurrent checks on the decoder's fetch, decode and feedback ports
`timescale 1ns/1ps
`default_nettype none
module ifd_dec_chk (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        fetch_valid,
  input wire logic [31:0] fetch_instr,
  input wire logic [31:0] fetch_pc,
  input wire logic        exe_result_valid,
  input wire logic [4:0]  exe_trap_cmp,
  input wire logic        dec_valid_ff,
  input wire logic [5:0]  opcode_ff,
  input wire logic [2:0]  cr_field_dest_ff,
  input wire logic [31:0] compare_imm_ff,
  input wire logic [31:0] branch_target_ff,
  input wire logic        link_wr_ff,
  input wire logic [31:0] link_addr_ff,
  input wire logic        record_ff,
  input wire logic [4:0]  trap_condition_mask_ff,
  input wire logic        cr_wr_ff,
  input wire logic        trap_ff
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  property p_opc; dec_valid_ff |-> opcode_ff == $past(fetch_instr[31:26]); endproperty
  a_opc: assert property (p_opc) else $error("opcode field wrong");
  property p_dec; dec_valid_ff |-> $past(fetch_valid); endproperty
  a_dec: assert property (p_dec) else $error("decode without fetch");
  property p_crf; dec_valid_ff |-> cr_field_dest_ff == $past(fetch_instr[25:23]); endproperty
  a_crf: assert property (p_crf) else $error("compare field wrong");
  property p_cim;
    dec_valid_ff |-> compare_imm_ff == {{16{$past(fetch_instr[15])}}, $past(fetch_instr[15:0])};
  endproperty
  a_cim: assert property (p_cim) else $error("compare immediate wrong");
  property p_abs;
    dec_valid_ff && $past(fetch_instr[1]) |->
      branch_target_ff == {{6{$past(fetch_instr[25])}}, $past(fetch_instr[25:2]), 2'b00};
  endproperty
  a_abs: assert property (p_abs) else $error("absolute target wrong");
  property p_lnk;
    dec_valid_ff && $past(fetch_instr[0]) |->
      link_wr_ff && link_addr_ff == $past(fetch_pc) + 32'h4;
  endproperty
  a_lnk: assert property (p_lnk) else $error("link write wrong");
  property p_rec; cr_wr_ff |-> $past(exe_result_valid && record_ff); endproperty
  a_rec: assert property (p_rec) else $error("condition write without record");
  property p_trp;
    exe_result_valid && |(trap_condition_mask_ff & exe_trap_cmp) |=> trap_ff;
  endproperty
  a_trp: assert property (p_trp) else $error("trap missed");
  c_lnk: cover property (dec_valid_ff && link_wr_ff);
  c_rec: cover property (cr_wr_ff);
  c_trp: cover property (trap_ff);
endmodule // ifd_dec_chk
bind ifd_decoder ifd_dec_chk u_chk (.*);
`default_nettype wire

//--- tb/ifd_exec_model.sv
// Execute-stage stand-in that answers a decoded word lat+1 cycles later; a lat of zero gives no answer
`timescale 1ns/1ps
`default_nettype none
module ifd_exec_model (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        dec_valid,
  input  wire logic [1:0]  lat,
  input  wire logic [31:0] res_in,
  input  wire logic        ovf_in,
  input  wire logic [4:0]  cmp_in,
  output logic             exe_result_valid,
  output logic [31:0]      exe_result,
  output logic             exe_overflow,
  output logic [4:0]       exe_trap_cmp
);
  logic [1:0] cnt;
  // Outside a result the lines toggle so stale values never look valid
  always @(posedge mclk) begin
    if (sys_rst) begin
      cnt <= 2'h0;
      exe_result_valid <= 1'b0;
      exe_result <= 32'h0;
      exe_overflow <= 1'b0;
      exe_trap_cmp <= 5'h0;
    end else begin
      if (dec_valid && lat != 2'h0) cnt <= lat;
      else if (cnt != 2'h0) cnt <= cnt - 2'h1;
      exe_result_valid <= (cnt == 2'h1);
      exe_result <= (cnt == 2'h1) ? res_in : ~exe_result;
      exe_overflow <= (cnt == 2'h1) ? ovf_in : ~exe_overflow;
      exe_trap_cmp <= (cnt == 2'h1) ? cmp_in : ~exe_trap_cmp;
    end
  end
endmodule // ifd_exec_model
`default_nettype wire

//--- tb/test_instruction_field_decoder.sv
// Self-checking bench for the instruction field decoder
`timescale 1ns/1ps
`include "ifd_defs.vh"
`default_nettype none
module test_instruction_field_decoder;
  logic mclk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, fetch_valid = 0, ovf_in = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 0, fetch_instr = 0, fetch_pc = 0, res_in = 0, prdata, exe_result;
  logic [4:0] cmp_in = 0, exe_trap_cmp, trap_condition_mask_ff, cr_src_bit_a_ff, cr_src_bit_b_ff;
  logic [1:0] lat = 0;
  logic pready, pslverr, exe_result_valid, exe_overflow, dec_valid_ff, absolute_addr_flag_ff;
  logic link_flag_ff, link_wr_ff, ovf_enable_ff, record_ff, rsv_nonzero_ff, cr_wr_ff;
  logic xer_ov_ff, xer_so_ff, trap_ff;
  logic [5:0] opcode_ff, string_byte_count_ff;
  logic [9:0] ext_opcode_ff;
  logic [4:0] gpr_dest_ff, gpr_store_src_ff, gpr_src_a_ff, gpr_src_b_ff, fpr_dest_ff;
  logic [4:0] fpr_store_src_ff, fpr_src_a_ff, fpr_src_b_ff, fpr_src_c_ff, cr_dest_bit_ff;
  logic [4:0] mask_begin_ff, mask_end_bit_ff;
  logic [2:0] cr_field_dest_ff;
  logic [3:0] cr0_ff, ec0;
  logic [31:0] disp_imm_ff, compare_imm_ff, unsigned_imm_ff, ea_disp_ff, cond_branch_disp_ff;
  logic [31:0] cond_branch_target_ff, branch_target_ff, link_addr_ff;
  logic [31:0] rng = 32'h0000_B262, rd, i, p, bd, li, cur = 0, lastw = 0;
  logic [5:0] ops [5] = '{`IFD_OP_CMPLI, `IFD_OP_CMPI, `IFD_OP_EXT31, 6'h12, 6'h10};
  logic [63:0] q [$];
  logic en = 1, pend = 0, er, et, ov = 0, so = 0, ovs = 0, trs = 0, rsv = 0, e;
  int error_cnt = 0, n_compared = 0, nacc = 0, k;
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  ifd_decoder u_dut (.*);
  ifd_exec_model u_exe (.mclk(mclk), .sys_rst(sys_rst), .dec_valid(dec_valid_ff), .lat(lat),
    .res_in(res_in), .ovf_in(ovf_in), .cmp_in(cmp_in), .exe_result_valid(exe_result_valid),
    .exe_result(exe_result), .exe_overflow(exe_overflow), .exe_trap_cmp(exe_trap_cmp));
  function logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function logic rsvf(input logic [31:0] w);
    return w[21] && (w[31:26] == `IFD_OP_CMPLI || w[31:26] == `IFD_OP_CMPI ||
      (w[31:26] == `IFD_OP_EXT31 && (w[10:1] == `IFD_XO_CMP || w[10:1] == `IFD_XO_CMPL)));
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask
  task tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Idle edge after release keeps psel from being driven twice in one step
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge mclk);
  endtask
  task fetch(input logic [31:0] w);
    p = xs(w);
    fetch_valid <= 1;
    fetch_instr <= w;
    fetch_pc <= {p[31:2], 2'b00};
    @(posedge mclk);
  endtask
  always @(posedge mclk) begin
    if (!sys_rst) begin
      if (pend) begin
        chk({cr_wr_ff, trap_ff}, {er, et});
        chk({xer_ov_ff, xer_so_ff}, {ov, so});
        if (er) chk(cr0_ff, ec0);
        pend = 0;
      end
      if (dec_valid_ff && q.size() == 0) chk(dec_valid_ff, 0);
      else if (dec_valid_ff) begin
        {p, i} = q.pop_front();
        cur = i;
        bd = {{16{i[15]}}, i[15:2], 2'b00};
        li = {{6{i[25]}}, i[25:2], 2'b00};
        chk(opcode_ff, i[31:26]);
        chk(ext_opcode_ff, i[10:1]);
        chk({gpr_dest_ff, gpr_store_src_ff}, {i[25:21], i[25:21]});
        chk({gpr_src_a_ff, gpr_src_b_ff}, i[20:11]);
        chk({fpr_dest_ff, fpr_store_src_ff, fpr_src_a_ff, fpr_src_b_ff, fpr_src_c_ff},
          {i[25:21], i[25:6]});
        chk({cr_dest_bit_ff, cr_src_bit_a_ff, cr_src_bit_b_ff}, i[25:11]);
        chk(cr_field_dest_ff, i[25:23]);
        chk(disp_imm_ff, {{16{i[15]}}, i[15:0]});
        chk(compare_imm_ff, {{16{i[15]}}, i[15:0]});
        chk(unsigned_imm_ff, {16'h0000, i[15:0]});
        chk(ea_disp_ff, bd);
        chk(cond_branch_disp_ff, bd);
        chk(cond_branch_target_ff, i[1] ? bd : p + bd);
        chk(branch_target_ff, i[1] ? li : p + li);
        chk({absolute_addr_flag_ff, link_flag_ff, link_wr_ff}, {i[1], i[0], i[0]});
        chk(link_addr_ff, p + 32'h4);
        chk({mask_begin_ff, mask_end_bit_ff}, i[10:1]);
        chk(string_byte_count_ff, i[15:11] == 5'h0 ? 6'h20 : {1'b0, i[15:11]});
        chk(ovf_enable_ff, i[10]);
        chk(trap_condition_mask_ff, i[25:21]);
        chk(record_ff, i[0]);
        chk(rsv_nonzero_ff, rsvf(i));
      end
      if (exe_result_valid) begin
        er = cur[0];
        et = |(cur[25:21] & exe_trap_cmp);
        trs = trs | et;
        if (cur[10]) ov = exe_overflow;
        if (cur[10] && exe_overflow) {so, ovs} = 2'h3;
        ec0 = {exe_result[31], !exe_result[31] && exe_result != 0, exe_result == 0, so};
        pend = 1;
      end
      if (fetch_valid && en) begin
        q.push_back({fetch_pc, fetch_instr});
        nacc++;
        lastw = fetch_instr;
        rsv = rsv | rsvf(fetch_instr);
      end
    end
  end
  initial begin
    repeat (16) @(posedge mclk);
    sys_rst <= 0;
    for (k = 0; k < 40; k++) begin
      rng = xs(rng);
      i = {ops[k % 5], rng[25:0]};
      if (k % 5 == 2) i[10:1] = k[0] ? `IFD_XO_CMP : `IFD_XO_CMPL;
      fetch(i);
    end
    for (k = 0; k < 12; k++) begin
      rng = xs(rng);
      ovf_in <= rng[0];
      cmp_in <= rng[5:1];
      res_in <= (k == 3) ? 32'h0 : xs(rng);
      lat <= k[0] ? 2'h3 : 2'h1;
      fetch(rng);
      fetch_valid <= 0;
      repeat (6) @(posedge mclk);
    end
    lat <= 0;
    apb(0, `IFD_REG_COUNT, 0);
    chk(rd, nacc);
    chk(e, 0);
    apb(0, `IFD_REG_LAST, 0);
    chk(rd, lastw);
    apb(0, `IFD_REG_STATUS, 0);
    chk(rd[3:0], {rsv, trs, so, ovs});
    apb(1, `IFD_REG_STATUS, 32'hF);
    apb(1, `IFD_REG_CTRL, 32'h3);
    {ov, so, ovs, trs, rsv} = 5'h0;
    apb(0, `IFD_REG_STATUS, 0);
    chk({rd[3:0], xer_ov_ff, xer_so_ff}, 0);
    apb(0, 12'h010, 0);
    chk(e, 1);
    chk(rd, 0);
    apb(1, `IFD_REG_CTRL, 32'h0);
    en = 0;
    for (k = 0; k < 3; k++) fetch(xs(rng + k));
    fetch_valid <= 0;
    repeat (4) @(posedge mclk);
    apb(0, `IFD_REG_COUNT, 0);
    chk(rd, nacc);
    tally_and_finish;
  end
  initial begin
    repeat (5000) @(posedge mclk);
    error_cnt++;
    tally_and_finish;
  end
endmodule // test_instruction_field_decoder
`default_nettype wire
